// *** shared/hot_swap_pkg.sv ***
// constants, register map and carrier types for the hot swap fault supervisor
package hot_swap_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int OV_QUAL_NS = 25000;
  localparam int OV_QUAL_TICKS = (OV_QUAL_NS + TICK_NS - 1) / TICK_NS;
  localparam int UV_QUAL_NS = 15000;
  localparam int UV_QUAL_TICKS = (UV_QUAL_NS + TICK_NS - 1) / TICK_NS;
  localparam int RETRY_NS = 50000000;
  localparam int RETRY_TICKS = (RETRY_NS + TICK_NS - 1) / TICK_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_TICKS = (MS_NS + TICK_NS - 1) / TICK_NS;
  localparam int COOL_CYCLES = 256;

  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MASK1 = 8'h02;
  localparam logic [7:0] ADDR_MASK2 = 8'h03;
  localparam logic [7:0] ADDR_FAULT = 8'h04;
  localparam logic [7:0] ADDR_CONV_ALARM = 8'h05;
  localparam logic [7:0] ADDR_DAMAGE_TIME = 8'h06;
  localparam logic [7:0] ADDR_PIN_SETUP = 8'h07;
  localparam logic [7:0] ADDR_ALERT_CTL = 8'h1C;
  localparam logic [7:0] ADDR_CONV_CTL = 8'h1D;
  localparam logic [7:0] ADDR_LIVE1 = 8'h1E;
  localparam logic [7:0] ADDR_LIVE2 = 8'h1F;

  localparam int CTL_OV_RETRY = 0;
  localparam int CTL_UV_RETRY = 1;
  localparam int CTL_OC_RETRY = 2;
  localparam int CTL_SW_EN = 3;
  localparam int CTL_POLARITY = 5;
  localparam int CTL_DEBOUNCE = 6;
  localparam int CTL_HOLD_MASK = 7;
  localparam int FLT_OV = 0;
  localparam int FLT_UV = 1;
  localparam int FLT_PBAD = 3;
  localparam int FLT_TOGGLE = 4;
  localparam int FLT_SHORT = 5;
  localparam int FLT_DAMAGE = 6;
  localparam int LIVE_PGOOD = 3;
  localparam int LIVE_ENABLE = 4;
  localparam int LIVE2_TICK_WRAP = 0;
  localparam int LIVE2_METER_WRAP = 1;
  localparam int LIVE2_ALERT_IN = 4;
  localparam int ALC_FAULT = 7;
  localparam int ALC_GPO = 6;
  localparam int PIN_WRAP_ALERT = 0;
  localparam int PIN_ADC_ALERT = 2;
  localparam int CONV_METER_RESET = 6;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef struct packed {
    logic highLimit;
    logic lowLimitOk;
    logic enablePin;
    logic vdsHigh;
    logic gateHigh;
    logic outputSense;
    logic timerCycle;
    logic alertIn;
  } pins_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wrEn;
    logic rdEn;
    logic [7:0] wrData;
  } reg_req_t;

  typedef enum logic [2:0] {
    DMG_IDLE = 3'b001,
    DMG_TIMING = 3'b010,
    DMG_COOL = 3'b100
  } damage_state_t;
endpackage

// *** rtl/hot_swap_fault_supervisor.sv ***
// fault qualification, switch control, fault records and alert line logic
//
// Notes on behaviour
// - high limit over 25us: switch off, record
// - overvoltage retry after 50ms below, if enabled
// - low limit under 15us: switch off, record
// - undervoltage retry after 50ms above, if enabled
// - control bit 5 sets enable polarity
// - control bit 6 adds 50ms turn-on debounce
// - enable toggle marks bit 4, clears others unless control bit 7 set
// - enable edges and writes steer switch-enable
// - boot loads switch-enable; latch enable after debounce
// - drain-source over 200mV flags damage
// - on but gate below 8V flags damage
// - damage timer in ms; zero disables
// - damage retries after 256 timer cycles
// - sense current with gate off: short
// - power-good live bit follows output sense
// - power-good pin gated until gate first high
// - power bad: sense low, gate high
// - host clears records by zero writes, overflows
// - masked faults set alert bit, drive line
// - alert response releases line unless arbitration lost
// - alert bit 6 pulls line; level readable
// - alert only on new fault occurrence or conversion alarm, or on wrap and ADC done if pin setup enables them
// - live fault blocks clearing its record
// - retry off: record holds switch off
`timescale 1ns/1ps
module hot_swap_fault_supervisor #(
  parameter int LONG_TICKS = hot_swap_pkg::RETRY_TICKS,
  parameter int MSEC_TICKS = hot_swap_pkg::MS_TICKS
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic rst_n,
  input wire hot_swap_pkg::pins_t pinsAsync,
  input wire logic adcShort,
  input wire logic adcDone,
  input wire logic [7:0] convAlarmSet,
  input wire logic tickWrap,
  input wire logic meterWrap,
  input wire logic [7:0] nvControl,
  input wire hot_swap_pkg::reg_req_t regReq,
  output logic [7:0] regRdData,
  input wire logic araRequest,
  input wire logic araLost,
  output logic gateOn,
  output logic powerGoodPin,
  output logic alertOut,
  output logic alertOe_n
);
  import hot_swap_pkg::*;

  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    hit = r.wrEn && (r.addr == a);
  endfunction

  pins_t pinsMeta_reg, pinsSync_reg;
  logic [15:0] tickCnt_reg, tickCnt_next;
  logic [7:0] control_reg, control_next, mask1_reg, mask1_next, mask2_reg, mask2_next;
  logic [7:0] faultRec_reg, faultRec_next, convAlarm_reg, convAlarm_next;
  logic [7:0] damageTimeout_reg, damageTimeout_next, pinSetup_reg, pinSetup_next;
  logic [7:0] alertCtl_reg, alertCtl_next, convCtl_reg, convCtl_next, regRdData_next;
  logic [7:0] livePrev_reg, liveRec;
  logic [1:0] qualLive_reg, qualLive_next, wrapLive_reg, wrapLive_next;
  logic [15:0] qualCnt_reg [2];
  logic [15:0] qualCnt_next [2];
  logic [15:0] stableCnt_reg, stableCnt_next, msPre_reg, msPre_next;
  logic [7:0] msCnt_reg, msCnt_next;
  logic [8:0] coolCnt_reg, coolCnt_next;
  damage_state_t dmgState_reg, dmgState_next;
  logic dmgLive_reg, dmgLive_next, enablePrev_reg, timerPrev_reg;
  logic bootPending_reg, bootPending_next, bootLatch_reg, bootLatch_next;
  logic ignoreEnable_reg, ignoreEnable_next, pgArmed_reg, pgArmed_next;
  logic gateOn_next, powerGoodPin_next, shortLive_reg, shortLive_next;
  logic tick, msPulse, enableActive, toggle, onReady, hold, cmdOn, dmgCond, powerBad;
  logic alertEvent, meterClear;
  logic [7:0] setEvents, live1, live2;
  logic [15:0] qualLimit [2];
  logic qualRaw [2];
  logic [2:0] warm_reg, warm_next;

  // two-stage sync on every pin; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinsMeta_reg <= '0;
      pinsSync_reg <= '0;
    end else if (ce) begin
      pinsMeta_reg <= pinsAsync;
      pinsSync_reg <= pinsMeta_reg;
    end
  end

  always_comb begin
    tick = (tickCnt_reg == 16'(TICK_CYCLES - 1));
    tickCnt_next = tick ? 16'h0000 : tickCnt_reg + 16'h0001;
    enableActive = control_reg[CTL_POLARITY] ? pinsSync_reg.enablePin : !pinsSync_reg.enablePin;
    // no edge until the sync stages and the previous-level flop all hold real pin samples
    warm_next = {warm_reg[1:0], 1'b1};
    toggle = (pinsSync_reg.enablePin != enablePrev_reg) && !bootPending_reg && warm_reg[2];
    dmgCond = pinsSync_reg.vdsHigh || (gateOn && !pinsSync_reg.gateHigh);
    powerBad = !pinsSync_reg.outputSense && pinsSync_reg.gateHigh;
    liveRec = {1'b0, dmgLive_reg, shortLive_reg, 1'b0, powerBad, 1'b0, qualLive_reg};
    // a live fault raises its record on its rising edge only; the toggle record is set on every enable-pin edge
    setEvents = (liveRec & ~livePrev_reg) | {3'b000, toggle, 4'h0};
    live1 = {1'b0, dmgLive_reg, shortLive_reg, enableActive, pinsSync_reg.outputSense, 1'b0, qualLive_reg};
    live1[LIVE_PGOOD] = pinsSync_reg.outputSense;
    live2 = {3'b000, pinsSync_reg.alertIn, 2'b00, wrapLive_reg};

    // overvoltage / undervoltage qualification and retry windows
    qualRaw[0] = pinsSync_reg.highLimit;
    qualRaw[1] = !pinsSync_reg.lowLimitOk;
    qualLive_next = qualLive_reg;
    for (int i = 0; i < 2; i++) begin
      qualLimit[i] = qualLive_reg[i] ? 16'(LONG_TICKS) : (i == 0 ? 16'(OV_QUAL_TICKS) : 16'(UV_QUAL_TICKS));
      qualCnt_next[i] = qualCnt_reg[i];
      if (qualRaw[i] == qualLive_reg[i]) begin
        qualCnt_next[i] = 16'h0000;
      end else if (tick) begin
        if (qualCnt_reg[i] + 16'h0001 >= qualLimit[i]) begin
          qualLive_next[i] = qualRaw[i];
          qualCnt_next[i] = 16'h0000;
        end else begin
          qualCnt_next[i] = qualCnt_reg[i] + 16'h0001;
        end
      end
    end

    // switch-enable bit, boot latch and turn-on debounce
    control_next = control_reg;
    bootPending_next = 1'b0;
    bootLatch_next = bootLatch_reg;
    ignoreEnable_next = ignoreEnable_reg;
    stableCnt_next = toggle ? 16'h0000 : stableCnt_reg;
    if (tick && !toggle && stableCnt_reg < 16'(LONG_TICKS)) begin
      stableCnt_next = stableCnt_reg + 16'h0001;
    end
    if (bootPending_reg) begin
      // nonvolatile defaults are caught one cycle after reset release
      control_next = nvControl & ~8'(1 << CTL_SW_EN);
      bootLatch_next = nvControl[CTL_SW_EN];
      ignoreEnable_next = !nvControl[CTL_SW_EN];
    end else if (hit(regReq, ADDR_CONTROL)) begin
      control_next = regReq.wrData;
      ignoreEnable_next = 1'b0;
      bootLatch_next = 1'b0;
    end else if (bootLatch_reg && stableCnt_reg >= 16'(LONG_TICKS)) begin
      control_next[CTL_SW_EN] = enableActive;
      bootLatch_next = 1'b0;
    end else if (toggle && !ignoreEnable_reg && !bootLatch_reg) begin
      control_next[CTL_SW_EN] = enableActive;
    end
    onReady = !control_reg[CTL_DEBOUNCE] || stableCnt_reg >= 16'(LONG_TICKS);
    cmdOn = control_reg[CTL_SW_EN] && onReady && !bootLatch_reg;

    // damage timer: counts whole milliseconds while the condition lasts
    dmgState_next = dmgState_reg;
    msPre_next = msPre_reg;
    msCnt_next = msCnt_reg;
    coolCnt_next = coolCnt_reg;
    dmgLive_next = dmgLive_reg;
    msPulse = tick && (msPre_reg == 16'(MSEC_TICKS - 1));
    unique case (dmgState_reg)
      DMG_IDLE: begin
        msPre_next = 16'h0000;
        msCnt_next = 8'h00;
        if (dmgCond && cmdOn && damageTimeout_reg != 8'h00) begin
          dmgState_next = DMG_TIMING;
        end
      end
      DMG_TIMING: begin
        if (!(dmgCond && cmdOn) || damageTimeout_reg == 8'h00) begin
          dmgState_next = DMG_IDLE;
        end else if (tick) begin
          msPre_next = msPulse ? 16'h0000 : msPre_reg + 16'h0001;
          if (msPulse) begin
            msCnt_next = msCnt_reg + 8'h01;
            if (msCnt_reg + 8'h01 >= damageTimeout_reg) begin
              dmgLive_next = 1'b1;
              coolCnt_next = 9'h000;
              dmgState_next = DMG_COOL;
            end
          end
        end
      end
      DMG_COOL: begin
        if (pinsSync_reg.timerCycle && !timerPrev_reg) begin
          coolCnt_next = coolCnt_reg + 9'h001;
          if (coolCnt_reg + 9'h001 >= 9'(COOL_CYCLES)) begin
            dmgLive_next = 1'b0;
            dmgState_next = DMG_IDLE;
          end
        end
      end
      default: dmgState_next = DMG_IDLE;
    endcase

    // with retry off the record keeps the switch off until cleared
    hold = qualLive_reg[0] || (!control_reg[CTL_OV_RETRY] && faultRec_reg[FLT_OV])
      || qualLive_reg[1] || (!control_reg[CTL_UV_RETRY] && faultRec_reg[FLT_UV])
      || dmgLive_reg || (!control_reg[CTL_OC_RETRY] && faultRec_reg[FLT_DAMAGE]);
    gateOn_next = cmdOn && !hold && !bootPending_reg;
    shortLive_next = adcShort && !gateOn;
    pgArmed_next = pgArmed_reg || pinsSync_reg.gateHigh;
    powerGoodPin_next = pgArmed_reg && pinsSync_reg.outputSense;

    // fault record: writes clear, live faults refuse, new events set last
    faultRec_next = faultRec_reg;
    if (hit(regReq, ADDR_FAULT)) begin
      faultRec_next = regReq.wrData | (faultRec_reg & liveRec);
    end
    if (toggle && !control_reg[CTL_HOLD_MASK]) begin
      faultRec_next = faultRec_next & liveRec;
    end
    faultRec_next = faultRec_next | setEvents;
    convAlarm_next = hit(regReq, ADDR_CONV_ALARM) ? regReq.wrData : convAlarm_reg;
    convAlarm_next = convAlarm_next | convAlarmSet;

    mask1_next = hit(regReq, ADDR_MASK1) ? regReq.wrData : mask1_reg;
    mask2_next = hit(regReq, ADDR_MASK2) ? regReq.wrData : mask2_reg;
    damageTimeout_next = hit(regReq, ADDR_DAMAGE_TIME) ? regReq.wrData : damageTimeout_reg;
    pinSetup_next = hit(regReq, ADDR_PIN_SETUP) ? regReq.wrData : pinSetup_reg;
    convCtl_next = hit(regReq, ADDR_CONV_CTL) ? regReq.wrData : convCtl_reg;
    // overflow flags clear on the falling write of the meter reset bit
    meterClear = convCtl_reg[CONV_METER_RESET] && !convCtl_next[CONV_METER_RESET];
    wrapLive_next = (meterClear ? 2'b00 : wrapLive_reg) | {meterWrap, tickWrap};

    alertEvent = |(setEvents & mask1_reg) || |(convAlarmSet & mask2_reg)
      || (pinSetup_reg[PIN_WRAP_ALERT] && (tickWrap || meterWrap))
      || (pinSetup_reg[PIN_ADC_ALERT] && adcDone);
    alertCtl_next = hit(regReq, ADDR_ALERT_CTL) ? regReq.wrData : alertCtl_reg;
    if (araRequest && !araLost) begin
      alertCtl_next[ALC_FAULT] = 1'b0;
    end
    if (alertEvent) begin
      alertCtl_next[ALC_FAULT] = 1'b1;
    end

    regRdData_next = regRdData;
    if (regReq.rdEn) begin
      unique case (regReq.addr)
        ADDR_CONTROL: regRdData_next = control_reg;
        ADDR_MASK1: regRdData_next = mask1_reg;
        ADDR_MASK2: regRdData_next = mask2_reg;
        ADDR_FAULT: regRdData_next = faultRec_reg;
        ADDR_CONV_ALARM: regRdData_next = convAlarm_reg;
        ADDR_DAMAGE_TIME: regRdData_next = damageTimeout_reg;
        ADDR_PIN_SETUP: regRdData_next = pinSetup_reg;
        ADDR_ALERT_CTL: regRdData_next = alertCtl_reg;
        ADDR_CONV_CTL: regRdData_next = convCtl_reg;
        ADDR_LIVE1: regRdData_next = live1;
        ADDR_LIVE2: regRdData_next = live2;
        default: regRdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCnt_reg <= 16'h0000;
      control_reg <= REG_RESET;
      mask1_reg <= REG_RESET;
      mask2_reg <= REG_RESET;
      faultRec_reg <= REG_RESET;
      convAlarm_reg <= REG_RESET;
      damageTimeout_reg <= REG_RESET;
      pinSetup_reg <= REG_RESET;
      alertCtl_reg <= REG_RESET;
      convCtl_reg <= REG_RESET;
      regRdData <= 8'h00;
      livePrev_reg <= 8'h00;
      qualLive_reg <= 2'b00;
      qualCnt_reg[0] <= 16'h0000;
      qualCnt_reg[1] <= 16'h0000;
      wrapLive_reg <= 2'b00;
      stableCnt_reg <= 16'h0000;
      msPre_reg <= 16'h0000;
      msCnt_reg <= 8'h00;
      coolCnt_reg <= 9'h000;
      dmgState_reg <= DMG_IDLE;
      dmgLive_reg <= 1'b0;
      enablePrev_reg <= 1'b0;
      warm_reg <= 3'h0;
      timerPrev_reg <= 1'b0;
      bootPending_reg <= 1'b1;
      bootLatch_reg <= 1'b0;
      ignoreEnable_reg <= 1'b1;
      pgArmed_reg <= 1'b0;
      gateOn <= 1'b0;
      powerGoodPin <= 1'b0;
      shortLive_reg <= 1'b0;
    end else if (ce) begin
      tickCnt_reg <= tickCnt_next;
      control_reg <= control_next;
      mask1_reg <= mask1_next;
      mask2_reg <= mask2_next;
      faultRec_reg <= faultRec_next;
      convAlarm_reg <= convAlarm_next;
      damageTimeout_reg <= damageTimeout_next;
      pinSetup_reg <= pinSetup_next;
      alertCtl_reg <= alertCtl_next;
      convCtl_reg <= convCtl_next;
      regRdData <= regRdData_next;
      livePrev_reg <= liveRec;
      qualLive_reg <= qualLive_next;
      qualCnt_reg <= qualCnt_next;
      wrapLive_reg <= wrapLive_next;
      stableCnt_reg <= stableCnt_next;
      msPre_reg <= msPre_next;
      msCnt_reg <= msCnt_next;
      coolCnt_reg <= coolCnt_next;
      dmgState_reg <= dmgState_next;
      dmgLive_reg <= dmgLive_next;
      enablePrev_reg <= pinsSync_reg.enablePin;
      warm_reg <= warm_next;
      timerPrev_reg <= pinsSync_reg.timerCycle;
      bootPending_reg <= bootPending_next;
      bootLatch_reg <= bootLatch_next;
      ignoreEnable_reg <= ignoreEnable_next;
      pgArmed_reg <= pgArmed_next;
      gateOn <= gateOn_next;
      powerGoodPin <= powerGoodPin_next;
      shortLive_reg <= shortLive_next;
    end
  end

  // open-drain alert: the level is always low, only the enable moves
  assign alertOut = 1'b0;
  assign alertOe_n = !(alertCtl_reg[ALC_FAULT] || alertCtl_reg[ALC_GPO]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // each check except a_pg_gated and a_alert_drives looks only at edges where the clock enable let state move
  a_ov_gate_off: assert property (qualLive_reg[0] && ce |=> !gateOn)
    else $error("gate on during overvoltage");
  a_uv_gate_off: assert property (qualLive_reg[1] && ce |=> !gateOn)
    else $error("gate on during undervoltage");
  a_ov_record_set: assert property ($rose(qualLive_reg[0]) && ce |=> faultRec_reg[FLT_OV])
    else $error("overvoltage record missed");
  a_record_refuse: assert property (hit(regReq, ADDR_FAULT) && ce
    |=> (faultRec_reg[1:0] & $past(qualLive_reg)) == $past(qualLive_reg))
    else $error("live fault record cleared");
  a_toggle_marks: assert property (toggle && ce |=> faultRec_reg[FLT_TOGGLE])
    else $error("toggle not recorded");
  a_pg_gated: assert property (!pgArmed_reg |=> !powerGoodPin)
    else $error("power good before gate high");
  a_pg_follows: assert property (pgArmed_reg && ce |=> powerGoodPin == $past(pinsSync_reg.outputSense))
    else $error("power good pin not following output sense");
  a_alert_drives: assert property (alertCtl_reg[ALC_FAULT] |-> !alertOe_n)
    else $error("alert bit set but line free");
  a_ara_release: assert property (araRequest && !araLost && !alertEvent && ce
    && !hit(regReq, ADDR_ALERT_CTL) |=> !alertCtl_reg[ALC_FAULT])
    else $error("alert not released on response");
  // a device that lost arbitration keeps pulling until a later broadcast
  a_ara_lost_keep: assert property (araRequest && araLost && alertCtl_reg[ALC_FAULT] && ce
    && !hit(regReq, ADDR_ALERT_CTL) |=> alertCtl_reg[ALC_FAULT])
    else $error("alert released after lost arbitration");
  a_damage_off: assert property (damageTimeout_reg == 8'h00 && ce |=> dmgState_reg != DMG_TIMING)
    else $error("damage timer runs while disabled");
  a_damage_hold: assert property (dmgLive_reg && ce |=> !gateOn)
    else $error("gate on during damage cooldown");
  a_short_flag: assert property (adcShort && !gateOn && ce
    |=> shortLive_reg and (ce |=> faultRec_reg[FLT_SHORT]))
    else $error("switch short not flagged");
  a_retry_hold: assert property (ce && (!control_reg[CTL_OV_RETRY] && faultRec_reg[FLT_OV]
    || !control_reg[CTL_UV_RETRY] && faultRec_reg[FLT_UV]) |=> !gateOn)
    else $error("record did not hold switch off");

  c_ov_fault: cover property ($rose(qualLive_reg[0]));
  c_damage_fault: cover property ($rose(dmgLive_reg));
  c_ara_release: cover property (alertCtl_reg[ALC_FAULT] ##1 !alertCtl_reg[ALC_FAULT]);
  c_gate_on: cover property ($rose(gateOn));
  c_short_fault: cover property ($rose(shortLive_reg));
endmodule

// *** dv/switch_partner.sv ***
// behavioural model of the pass switch, its comparators and the alert wire pull-up
`timescale 1ns/1ps
module switch_partner (
  input wire logic clk,
  input wire logic gateOn,
  input wire logic alertOut,
  input wire logic alertOe_n,
  input wire logic damaged,
  output logic gateHigh,
  output logic outputSense,
  output logic vdsHigh,
  output logic timerCycle,
  output logic alertIn
);
  logic [3:0] gateDelay;
  initial begin
    gateDelay = 4'h0;
    timerCycle = 1'b0;
  end
  // the gate needs a few cycles to climb past full enhancement
  always @(posedge clk) begin
    gateDelay <= {gateDelay[2:0], gateOn};
  end
  assign gateHigh = gateDelay[3];
  // output rises before full enhancement but never drops while the gate is still high
  assign outputSense = gateDelay[1] | gateDelay[3];
  // drain-source drop while the gate is commanded on and still enhancing, or for as long as it is commanded on once damaged
  assign vdsHigh = gateOn & (~gateHigh | damaged);
  // cooldown timer runs at its own rate, unrelated in phase, and only with the switch off
  initial begin
    #137;
    forever begin
      #400;
      timerCycle = gateOn ? 1'b0 : ~timerCycle;
    end
  end
  // pull-up: the wire only reads low while someone pulls it
  assign alertIn = alertOe_n ? 1'b1 : alertOut;
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the hot swap fault supervisor
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top;
  import hot_swap_pkg::*;
  // shortened long counts keep the run brief; expectations below follow them
  localparam int LONG = 20;
  localparam int MSEC = 4;
  logic clk, rst_n, adcShort, araRequest, araLost, highLimit, lowLimitOk, enablePin, tickWrap, damaged;
  logic gateOn, powerGoodPin, alertOut, alertOe_n, gateHigh, outputSense, vdsHigh, timerCycle, alertIn;
  pins_t pins;
  reg_req_t regReq;
  logic [7:0] regRdData, rdVal, ctlVal, rndData;
  logic [7:0] zeroAddrs [11] = '{ADDR_CONTROL, 8'h01, ADDR_MASK1, ADDR_MASK2, ADDR_FAULT, ADDR_CONV_ALARM,
    ADDR_DAMAGE_TIME, ADDR_PIN_SETUP, ADDR_ALERT_CTL, ADDR_CONV_CTL, ADDR_LIVE1};
  logic [7:0] rwAddrs [4] = '{ADDR_MASK1, ADDR_MASK2, ADDR_DAMAGE_TIME, ADDR_PIN_SETUP};
  int err_count, checks, seed;
  assign pins = {highLimit, lowLimitOk, enablePin, vdsHigh, gateHigh, outputSense, timerCycle, alertIn};
  hot_swap_fault_supervisor #(.LONG_TICKS(LONG), .MSEC_TICKS(MSEC)) hot_swap_fault_supervisor_inst (
    .clk(clk), .ce(1'b1), .rst_n(rst_n), .pinsAsync(pins), .adcShort(adcShort), .adcDone(1'b0),
    .convAlarmSet(8'h00), .tickWrap(tickWrap), .meterWrap(1'b0), .nvControl(8'h00), .regReq(regReq),
    .regRdData(regRdData), .araRequest(araRequest), .araLost(araLost), .gateOn(gateOn),
    .powerGoodPin(powerGoodPin), .alertOut(alertOut), .alertOe_n(alertOe_n));
  switch_partner switch_partner_inst (.clk(clk), .gateOn(gateOn), .alertOut(alertOut), .alertOe_n(alertOe_n),
    .damaged(damaged), .gateHigh(gateHigh), .outputSense(outputSense), .vdsHigh(vdsHigh),
    .timerCycle(timerCycle), .alertIn(alertIn));

  function automatic logic [7:0] bitv(input int pos);
    return 8'h01 << pos;
  endfunction
  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    regReq <= '{addr: addr, wrEn: 1'b1, rdEn: 1'b0, wrData: data};
    @(posedge clk);
    regReq <= '{addr: addr, wrEn: 1'b0, rdEn: 1'b0, wrData: data};
  endtask
  task automatic regRead(input logic [7:0] addr);
    @(posedge clk);
    regReq <= '{addr: addr, wrEn: 1'b0, rdEn: 1'b1, wrData: 8'h00};
    @(posedge clk);
    regReq <= '{addr: addr, wrEn: 1'b0, rdEn: 1'b0, wrData: 8'h00};
    #1;
    rdVal = regRdData;
  endtask
  // bounded wait; running out ends the run as a mismatch
  task automatic waitGate(input logic val, input int limit);
    int n;
    n = 0;
    checks++;
    while (gateOn !== val && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (gateOn !== val) begin
      err_count++;
      $display("wrong value at %0t ns: switch command never reached %b", $time, val);
      end_of_test();
    end
  endtask
  task automatic araPulse(input logic lost);
    @(posedge clk);
    araRequest <= 1'b1;
    araLost <= lost;
    @(posedge clk);
    araRequest <= 1'b0;
    araLost <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    seed = 66516;
    err_count = 0;
    checks = 0;
    rst_n = 1'b0;
    regReq = '0;
    {adcShort, araRequest, araLost, highLimit, tickWrap, damaged} = 6'h00;
    lowLimitOk = 1'b1;
    enablePin = 1'b1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // default says stay off and ignore the pin, even past the debounce time
    pause(300);
    `CHK(gateOn, 1'b0)
    foreach (zeroAddrs[i]) begin
      regRead(zeroAddrs[i]);
      `CHK(rdVal, 8'h00)
    end
    regWrite(ADDR_LIVE2, 8'hFF);
    regRead(ADDR_LIVE2);
    `CHK(rdVal, bitv(LIVE2_ALERT_IN))
    ctlVal = bitv(CTL_OV_RETRY) | bitv(CTL_UV_RETRY) | bitv(CTL_OC_RETRY) | bitv(CTL_SW_EN) | bitv(CTL_POLARITY);
    regWrite(ADDR_CONTROL, ctlVal);
    waitGate(1'b1, 20);
    pause(10);
    `CHK(powerGoodPin, 1'b1)
    regRead(ADDR_LIVE1);
    `CHK(rdVal, bitv(LIVE_PGOOD) | bitv(LIVE_ENABLE))
    for (int i = 0; i < 8; i++) begin
      rndData = 8'($random(seed));
      regWrite(rwAddrs[i % 4], rndData);
      regRead(rwAddrs[i % 4]);
      `CHK(rdVal, rndData)
    end
    foreach (rwAddrs[i]) regWrite(rwAddrs[i], 8'h00);
    regWrite(ADDR_MASK1, bitv(FLT_OV));
    // overvoltage: short of the qualifying time nothing happens
    @(posedge clk);
    highLimit <= 1'b1;
    pause(200);
    `CHK(gateOn, 1'b1)
    waitGate(1'b0, 100);
    regRead(ADDR_FAULT);
    `CHK(rdVal, bitv(FLT_OV))
    `CHK(alertOe_n, 1'b0)
    regWrite(ADDR_FAULT, 8'h00);
    regRead(ADDR_FAULT);
    `CHK(rdVal, bitv(FLT_OV))
    @(posedge clk);
    highLimit <= 1'b0;
    pause(150);
    `CHK(gateOn, 1'b0)
    waitGate(1'b1, 100);
    regWrite(ADDR_FAULT, 8'h00);
    regRead(ADDR_FAULT);
    `CHK(rdVal, 8'h00)
    araPulse(1'b1);
    `CHK(alertOe_n, 1'b0)
    araPulse(1'b0);
    `CHK(alertOe_n, 1'b1)
    regWrite(ADDR_ALERT_CTL, bitv(ALC_GPO));
    pause(4);
    `CHK(alertOe_n, 1'b0)
    regRead(ADDR_LIVE2);
    `CHK(rdVal, 8'h00)
    regWrite(ADDR_ALERT_CTL, 8'h00);
    // ticker wrap shows live, then the meter reset pulse clears it
    @(posedge clk);
    tickWrap <= 1'b1;
    @(posedge clk);
    tickWrap <= 1'b0;
    regRead(ADDR_LIVE2);
    `CHK(rdVal, bitv(LIVE2_ALERT_IN) | bitv(LIVE2_TICK_WRAP))
    regWrite(ADDR_CONV_CTL, bitv(CONV_METER_RESET));
    regWrite(ADDR_CONV_CTL, 8'h00);
    regRead(ADDR_LIVE2);
    `CHK(rdVal, bitv(LIVE2_ALERT_IN))
    // undervoltage with its retry off: the record alone keeps the switch off
    ctlVal = ctlVal & ~bitv(CTL_UV_RETRY);
    regWrite(ADDR_CONTROL, ctlVal);
    @(posedge clk);
    lowLimitOk <= 1'b0;
    pause(110);
    `CHK(gateOn, 1'b1)
    waitGate(1'b0, 80);
    @(posedge clk);
    lowLimitOk <= 1'b1;
    pause(400);
    `CHK(gateOn, 1'b0)
    @(posedge clk);
    adcShort <= 1'b1;
    pause(2);
    regRead(ADDR_LIVE1);
    `CHK(rdVal & bitv(FLT_SHORT), bitv(FLT_SHORT))
    @(posedge clk);
    adcShort <= 1'b0;
    regRead(ADDR_FAULT);
    `CHK(rdVal, bitv(FLT_UV) | bitv(FLT_SHORT))
    regWrite(ADDR_FAULT, 8'h00);
    waitGate(1'b1, 20);
    // pin falls, a short is logged meanwhile, then the pin returns
    @(posedge clk);
    enablePin <= 1'b0;
    waitGate(1'b0, 20);
    regRead(ADDR_CONTROL);
    `CHK(rdVal, ctlVal & ~bitv(CTL_SW_EN))
    @(posedge clk);
    adcShort <= 1'b1;
    repeat (3) @(posedge clk);
    adcShort <= 1'b0;
    pause(3);
    @(posedge clk);
    enablePin <= 1'b1;
    waitGate(1'b1, 20);
    regRead(ADDR_FAULT);
    `CHK(rdVal, bitv(FLT_TOGGLE))
    regRead(ADDR_CONTROL);
    `CHK(rdVal, ctlVal)
    ctlVal = ctlVal | bitv(CTL_DEBOUNCE);
    regWrite(ADDR_CONTROL, ctlVal);
    @(posedge clk);
    enablePin <= 1'b0;
    waitGate(1'b0, 20);
    @(posedge clk);
    enablePin <= 1'b1;
    pause(150);
    `CHK(gateOn, 1'b0)
    waitGate(1'b1, 100);
    // damaged switch: the timer trips after 1ms, then the cooldown runs out
    regWrite(ADDR_DAMAGE_TIME, 8'h01);
    @(posedge clk);
    damaged <= 1'b1;
    pause(20);
    `CHK(gateOn, 1'b1)
    waitGate(1'b0, 60);
    @(posedge clk);
    damaged <= 1'b0;
    regRead(ADDR_FAULT);
    `CHK(rdVal, bitv(FLT_TOGGLE) | bitv(FLT_DAMAGE))
    pause(1500);
    `CHK(gateOn, 1'b0)
    waitGate(1'b1, 1000);
    end_of_test();
  end
endmodule
